// ### hw/i2c_arb_pkg.sv
package i2c_arb_pkg;

  // Register word byte offsets on the bus.
  localparam logic [3:0] ADDR_SERIAL_TIMER_CONTROL = 4'h0;
  localparam logic [3:0] ADDR_CH0_STATUS           = 4'h4;
  localparam logic [3:0] ADDR_CH1_STATUS           = 4'h8;
  localparam logic [3:0] ADDR_CH0_MODE             = 4'hc;
  localparam logic [3:0] ADDR_CH1_MODE             = 4'h0;

  // Control register layout and reset value.
  localparam logic [7:0] CONTROL_RESET = 8'h00;
  localparam int         BIT_CH0_RATE = 5;
  localparam int         BIT_CH1_RATE = 6;

  // Status word layout, one per channel.
  localparam int BIT_LOST         = 2;
  localparam int BIT_SECOND_MATCH = 0;

  // Mode word layout; only channel 0 has a mode word.
  localparam int BIT_MASTER = 0;
  localparam int BIT_TX     = 1;
  localparam int BIT_FORMAT_SEL = 2;
  localparam int CKS_LSB    = 4;
  localparam int NCH        = 2;

  // Base rate divider: half period in clock cycles = base << (cks + 4*extend).
  localparam logic [11:0] HALF_BASE = 12'h001;

  localparam logic [31:0] READ_ZERO = 32'h0000_0000;

endpackage : i2c_arb_pkg

// ### hw/i2c_arbitration_and_rate_ctrl.sv
// How it works
// - In slave receive with format select 0, a second-address hit sets its flag.
// - As master transmitter, data on the bus unlike ours sets arbitration-lost.
// - A status write clears arbitration-lost only with 0, after reading it as 1.
// - Data register write in transmit or read in receive clears arbitration-lost.
// - Master transmit: driven data unlike sampled SDA at SCL rise sets the flag.
// - Master transmit: our clock still high at SCL pin fall sets the flag.
// - Shared control register is 8 bits, read and write, resets to zero.
// - Channel 1 extend bit and clock select feed a rate, but channel 1 has no mode word and stays slave.
// - Channel 0 extend bit with its clock select sets channel 0 master rate.
//
// Chosen here: the address map and register access over Wishbone.
`timescale 1ns/1ps
`default_nettype none
module i2c_arbitration_and_rate_ctrl
  import i2c_arb_pkg::*;
(
  // Clock and reset.
  input  wire logic              CLK,
  input  wire logic              RESET_N,
  // Wishbone slave.
  input  wire logic              CYC_I,
  input  wire logic              STB_I,
  input  wire logic              WE_I,
  input  wire logic [3:0]        ADR_I,
  input  wire logic [3:0]        SEL_I,
  input  wire logic [31:0]       DAT_I,
  output logic      [31:0]       DAT_O,
  output logic                   ACK_O,
  // Bus-side inputs per channel.
  input  wire logic [NCH-1:0]    SCL_I,
  input  wire logic [NCH-1:0]    SDA_I,
  input  wire logic [NCH-1:0]    SDA_DRIVE,
  input  wire logic [NCH-1:0]    BYTE_END,
  input  wire logic [NCH-1:0]    SECOND_ADDR_HIT,
  input  wire logic [NCH-1:0]    START_SEEN,
  input  wire logic [NCH-1:0]    DATA_REG_ACCESS_W,
  input  wire logic [NCH-1:0]    DATA_REG_ACCESS_R,
  // Bus-side outputs per channel.
  output logic      [NCH-1:0]    SCL_O,
  output logic      [NCH-1:0]    SCL_OE,
  output logic      [NCH-1:0]    SDA_O,
  output logic      [NCH-1:0]    SDA_OE,
  output logic      [NCH-1:0]    ARBITRATION_LOST_FLAG
);

  // All state but the output registers lives in one record so that reset and update always stay in step.
  // The seen bits remember that software has read a flag as set since it last rose.
  typedef struct packed {
    logic [7:0]     serial_timer_control;
    logic [NCH-1:0] arbitration_lost_flag;
    logic [NCH-1:0] lost_seen_one;
    logic [NCH-1:0] second_address_match_flag;
    logic [NCH-1:0] match_seen_one;
    logic [NCH-1:0] master;
    logic [NCH-1:0] tx;
    logic [NCH-1:0] second_address_format_select;
    logic [2:0]     cks0;
    logic [2:0]     cks1;
    logic [NCH-1:0] scl_prev;
    logic [NCH-1:0] scl_int;
    logic [NCH-1:0] sda_release;
    logic [11:0]    div0;
    logic [11:0]    div1;
    logic [31:0]    dat;
    logic           ack;
  } state_t;

  state_t s;
  state_t next_s;

  logic           req;
  logic           wr;
  logic           rd;
  logic [NCH-1:0] scl_rise;
  logic [NCH-1:0] scl_fall;
  logic [11:0]    half0;
  logic [11:0]    half1;

  // A request is taken once; the standing ack blocks a second take of the same cycle.
  // The answer therefore always comes exactly one clock after the request is seen.
  assign req = CYC_I && STB_I && !s.ack;
  assign wr  = req && WE_I && SEL_I[0];
  assign rd  = req && !WE_I;
  assign scl_rise = SCL_I & ~s.scl_prev;
  assign scl_fall = ~SCL_I & s.scl_prev;

  // The extend bit stretches the half period by sixteen, giving slow rates without
  // a wider select field.
  // channel zero and channel one rates
  assign half0 = HALF_BASE << ({1'b0, s.cks0}
                 + (s.serial_timer_control[BIT_CH0_RATE] ? 4'h4 : 4'h0));
  assign half1 = HALF_BASE << ({1'b0, s.cks1}
                 + (s.serial_timer_control[BIT_CH1_RATE] ? 4'h4 : 4'h0));

  always_comb
  begin
    next_s = s;
    next_s.ack = req;
    next_s.scl_prev = SCL_I;

    // Clock generators toggle our SCL at the selected half period.
    // A stopped generator parks high at once, so leaving master mode can cut a low phase short.
    // Changing the rate mid-byte takes effect at once, in the half period under way.
    if (!s.master[0])
    begin
      next_s.scl_int[0] = 1'b1;
      next_s.div0 = 12'h000;
    end
    else if (s.div0 + 12'h001 >= half0)
    begin
      next_s.div0 = 12'h000;
      next_s.scl_int[0] = ~s.scl_int[0];
    end
    else
    begin
      next_s.div0 = s.div0 + 12'h001;
    end
    if (!s.master[1])
    begin
      next_s.scl_int[1] = 1'b1;
      next_s.div1 = 12'h000;
    end
    else if (s.div1 + 12'h001 >= half1)
    begin
      next_s.div1 = 12'h000;
      next_s.scl_int[1] = ~s.scl_int[1];
    end
    else
    begin
      next_s.div1 = s.div1 + 12'h001;
    end

    // Register reads; a read of a set flag arms its clear.
    if (rd)
    begin
      case (ADR_I)
        ADDR_SERIAL_TIMER_CONTROL: next_s.dat = {24'h000000, s.serial_timer_control};
        ADDR_CH0_STATUS:
        begin
          next_s.dat = READ_ZERO;
          next_s.dat[BIT_LOST] = s.arbitration_lost_flag[0];
          next_s.dat[BIT_SECOND_MATCH] = s.second_address_match_flag[0];
          if (s.arbitration_lost_flag[0])
            next_s.lost_seen_one[0] = 1'b1;
          if (s.second_address_match_flag[0])
            next_s.match_seen_one[0] = 1'b1;
        end
        ADDR_CH1_STATUS:
        begin
          next_s.dat = READ_ZERO;
          next_s.dat[BIT_LOST] = s.arbitration_lost_flag[1];
          next_s.dat[BIT_SECOND_MATCH] = s.second_address_match_flag[1];
          if (s.arbitration_lost_flag[1])
            next_s.lost_seen_one[1] = 1'b1;
          if (s.second_address_match_flag[1])
            next_s.match_seen_one[1] = 1'b1;
        end
        ADDR_CH0_MODE:
        begin
          next_s.dat = READ_ZERO;
          next_s.dat[BIT_MASTER] = s.master[0];
          next_s.dat[BIT_TX] = s.tx[0];
          next_s.dat[BIT_FORMAT_SEL] = s.second_address_format_select[0];
          next_s.dat[CKS_LSB +: 3] = s.cks0;
        end
        // Channel one has no mode word, so it stays a slave and never drives the clock.
        // Its rate logic is kept so that mapping the word later needs no other change.
        default: next_s.dat = READ_ZERO;
      endcase
    end

    // Only byte lane zero carries register bits; writes without it change nothing.
    // Unmapped addresses ignore writes, which keeps stray software accesses harmless.
    if (wr)
    begin
      case (ADR_I)
        ADDR_SERIAL_TIMER_CONTROL: next_s.serial_timer_control = DAT_I[7:0];
        ADDR_CH0_STATUS:
        begin
          if (!DAT_I[BIT_LOST] && s.lost_seen_one[0])
          begin
            next_s.arbitration_lost_flag[0] = 1'b0;
            next_s.lost_seen_one[0] = 1'b0;
          end
          if (!DAT_I[BIT_SECOND_MATCH] && s.match_seen_one[0])
          begin
            next_s.second_address_match_flag[0] = 1'b0;
            next_s.match_seen_one[0] = 1'b0;
          end
        end
        ADDR_CH1_STATUS:
        begin
          if (!DAT_I[BIT_LOST] && s.lost_seen_one[1])
          begin
            next_s.arbitration_lost_flag[1] = 1'b0;
            next_s.lost_seen_one[1] = 1'b0;
          end
          if (!DAT_I[BIT_SECOND_MATCH] && s.match_seen_one[1])
          begin
            next_s.second_address_match_flag[1] = 1'b0;
            next_s.match_seen_one[1] = 1'b0;
          end
        end
        ADDR_CH0_MODE:
        begin
          next_s.master[0] = DAT_I[BIT_MASTER];
          next_s.tx[0] = DAT_I[BIT_TX];
          next_s.second_address_format_select[0] = DAT_I[BIT_FORMAT_SEL];
          next_s.cks0 = DAT_I[CKS_LSB +: 3];
        end
        default:
        begin
          next_s.dat = next_s.dat;
        end
      endcase
    end

    for (int c = 0; c < NCH; c++)
    begin
      if ((DATA_REG_ACCESS_W[c] && s.tx[c]) || (DATA_REG_ACCESS_R[c] && !s.tx[c]))
      begin
        next_s.arbitration_lost_flag[c] = 1'b0;
        next_s.lost_seen_one[c] = 1'b0;
      end
      // A flag cleared by hardware must be read as set again before a write clears it.
      if (START_SEEN[c] || s.master[c])
      begin
        next_s.second_address_match_flag[c] = 1'b0;
        next_s.match_seen_one[c] = 1'b0;
      end
      // Sets come last, so a set and a clear in one cycle leave the flag set.
      // second address match
      if (SECOND_ADDR_HIT[c] && !s.master[c] && !s.tx[c]
          && !s.second_address_format_select[c])
        next_s.second_address_match_flag[c] = 1'b1;
      // The shifter marks the byte boundary, after which we may drive data again.
      if (BYTE_END[c])
        next_s.sda_release[c] = 1'b0;
      // The clock pin is compared with its previous sample, so a glitch shorter than
      // one clock can be missed; the bus is far slower than the clock.
      // bus monitor, data mismatch, clock still high
      if (s.master[c] && s.tx[c]
          && ((scl_rise[c] && SDA_DRIVE[c] != SDA_I[c] && !s.sda_release[c])
              || (scl_fall[c] && s.scl_int[c])))
      begin
        next_s.arbitration_lost_flag[c] = 1'b1;
        next_s.sda_release[c] = 1'b1;
      end
    end
  end

  always_ff @(posedge CLK)
  begin
    if (!RESET_N)
    begin
      s <= '0;
      s.serial_timer_control <= CONTROL_RESET;
      s.scl_int <= '1;
      // An idle bus is high, so a low start value would fake a clock rise.
      s.scl_prev <= '1;
    end
    else
      s <= next_s;
  end

  always_ff @(posedge CLK)
  begin
    if (!RESET_N)
    begin
      DAT_O <= READ_ZERO;
      ACK_O <= 1'b0;
      SCL_O <= '0;
      SCL_OE <= '0;
      SDA_O <= '0;
      SDA_OE <= '0;
      ARBITRATION_LOST_FLAG <= '0;
    end
    else
    begin
      DAT_O <= next_s.dat;
      ACK_O <= next_s.ack;
      SCL_O <= '0;
      SCL_OE <= next_s.master & ~next_s.scl_int;
      SDA_O <= '0;
      // Open drain: a high enable pulls the line low, a released line floats high.
      // Registering from the next state keeps the pins in step with the flags.
      SDA_OE <= ~SDA_DRIVE & next_s.master & ~next_s.sda_release;
      ARBITRATION_LOST_FLAG <= next_s.arbitration_lost_flag;
    end
  end

endmodule : i2c_arbitration_and_rate_ctrl
`default_nettype wire

// ### tb/arb_chk.sv
`timescale 1ns/1ps
`default_nettype none
module arb_chk
  import i2c_arb_pkg::*;
(
  // Clock, reset and register bus.
  input wire logic            CLK,
  input wire logic            RESET_N,
  input wire logic            CYC_I,
  input wire logic            STB_I,
  input wire logic            WE_I,
  input wire logic [3:0]      ADR_I,
  input wire logic            ACK_O,
  // Bus side.
  input wire logic [NCH-1:0]  SCL_I,
  input wire logic [NCH-1:0]  DATA_REG_ACCESS_W,
  input wire logic [NCH-1:0]  DATA_REG_ACCESS_R,
  input wire logic [NCH-1:0]  SCL_OE,
  input wire logic [NCH-1:0]  SDA_OE,
  input wire logic [NCH-1:0]  ARBITRATION_LOST_FLAG
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!RESET_N);
  a_ack_once: assert property (CYC_I && STB_I && !ACK_O |=> ACK_O ##1 !ACK_O)
    else $error("ack is not a single pulse");
  a_ack_idle: assert property (!(CYC_I && STB_I) |=> !ACK_O)
    else $error("ack without request");
  a_lost_edge: assert property (
    $rose(ARBITRATION_LOST_FLAG[0]) |-> $past(SCL_I[0]) != $past(SCL_I[0], 2))
    else $error("lost flag set away from a clock edge");
  a_lost_clock: assert property (
    $rose(ARBITRATION_LOST_FLAG[0]) |-> !$past(SCL_OE[0]))
    else $error("lost flag set while pulling the clock");
  a_lost_fall: assert property ($fell(ARBITRATION_LOST_FLAG[0]) |->
    $past(DATA_REG_ACCESS_W[0] || DATA_REG_ACCESS_R[0]
    || (CYC_I && STB_I && WE_I && ADR_I == ADDR_CH0_STATUS)))
    else $error("lost flag cleared without cause");
  a_ch1_idle: assert property (!ARBITRATION_LOST_FLAG[1] && !SCL_OE[1])
    else $error("slave channel acts as master");
  a_sda_free: assert property ($rose(ARBITRATION_LOST_FLAG[0]) |=> !SDA_OE[0])
    else $error("data line pulled after loss");
  a_reset_clear: assert property (disable iff (1'b0) !RESET_N |=> !ACK_O
    && ARBITRATION_LOST_FLAG == 2'h0 && SDA_OE == 2'h0 && SCL_OE == 2'h0)
    else $error("outputs not cleared by reset");
endmodule : arb_chk
bind i2c_arbitration_and_rate_ctrl arb_chk i_chk (.CLK, .RESET_N, .CYC_I, .STB_I, .WE_I,
  .ADR_I, .ACK_O, .SCL_I, .DATA_REG_ACCESS_W, .DATA_REG_ACCESS_R, .SCL_OE, .SDA_OE,
  .ARBITRATION_LOST_FLAG);
`default_nettype wire

// ### tb/bus_peer.sv
`timescale 1ns/1ps
`default_nettype none
module bus_peer (
  // Pulls from our device and from the rival master.
  input  wire logic [1:0] scl_oe,
  input  wire logic [1:0] sda_oe,
  input  wire logic       grab_scl,
  input  wire logic       grab_sda,
  // Pulled-up wire levels.
  output logic      [1:0] scl,
  output logic      [1:0] sda
);
  assign sda = ~sda_oe & {1'b1, ~grab_sda};
  assign scl = ~scl_oe & {1'b1, ~grab_scl};
endmodule : bus_peer
`default_nettype wire

// ### tb/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import i2c_arb_pkg::*;
  logic        clk = 0, rst_n = 0, cyc = 0, stb = 0, we = 0, ack, gs = 0, gd = 0;
  logic [3:0]  adr = '0;
  logic [31:0] wd = '0, rd, q;
  logic [1:0]  drv = 2'h3, bend = '0, hit = '0, st = '0, aw = '0, ar = '0;
  logic [1:0]  scl, sda, scl_oe, sda_oe, flag, sclo, sdao;
  int          errors = 0, checks_done = 0, n, c;
  logic [20:0] rows [8] = '{21'h106000, 21'h000060, 21'h102000, 21'h000020,
                           21'h12ff00, 21'h020000, 21'h104000, 21'h000040};
  i2c_arbitration_and_rate_ctrl i_dut (.CLK(clk), .RESET_N(rst_n), .CYC_I(cyc), .STB_I(stb),
    .WE_I(we), .ADR_I(adr), .SEL_I(4'hf), .DAT_I(wd), .DAT_O(rd), .ACK_O(ack), .SCL_I(scl),
    .SDA_I(sda), .SDA_DRIVE(drv), .BYTE_END(bend), .SECOND_ADDR_HIT(hit), .START_SEEN(st),
    .DATA_REG_ACCESS_W(aw), .DATA_REG_ACCESS_R(ar), .SCL_O(sclo), .SCL_OE(scl_oe), .SDA_O(sdao),
    .SDA_OE(sda_oe), .ARBITRATION_LOST_FLAG(flag));
  bus_peer i_peer (.scl_oe(scl_oe), .sda_oe(sda_oe), .grab_scl(gs), .grab_sda(gd),
    .scl(scl), .sda(sda));
  always #20 clk = ~clk;
  task automatic stop_test();
    if (errors == 0 && checks_done > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : stop_test
  task automatic chk(input logic [31:0] g, e, input string m);
    checks_done++;
    if (g !== e)
    begin
      errors++;
      $display("CHECK FAILED %0t %s", $time, m);
    end
  endtask : chk
  task automatic hang();
    chk(0, 1, "wait ran out");
    stop_test();
  endtask : hang
  task automatic rw(input logic w, input logic [3:0] a, input logic [31:0] d);
    cyc <= 1;
    stb <= 1;
    we <= w;
    adr <= a;
    wd <= d;
    for (n = 0; n < 50 && ack !== 1'b1; n++)
      @(posedge clk);
    if (ack !== 1'b1) hang();
    q = rd;
    cyc <= 0;
    stb <= 0;
    @(posedge clk);
  endtask : rw
  task automatic acc(input logic w, r);
    aw <= {1'b0, w};
    ar <= {1'b0, r};
    @(posedge clk);
    aw <= 0;
    ar <= 0;
    repeat (2) @(posedge clk);
  endtask : acc
  // Clock loss needs a grab early in a released phase, not in our own pull.
  task automatic lose(input logic s);
    logic last;
    last = 1;
    for (n = 0; n < 200 && flag[0] !== 1'b1; n++)
    begin
      @(posedge clk);
      gd <= !s;
      if (s && scl[0] && !last) gs <= 1;
      last = scl[0];
    end
    if (flag[0] !== 1'b1) hang();
    gs <= 0;
    gd <= 0;
    @(posedge clk);
  endtask : lose
  task automatic wait_oe(input logic v);
    for (n = 0; n < 300 && scl_oe[0] !== v; n++)
      @(posedge clk);
    if (n == 300) hang();
  endtask : wait_oe
  initial
  begin
    repeat (20) @(posedge clk);
    rst_n <= 1;
    foreach (rows[i])
    begin
      rw(rows[i][20], rows[i][19:16], {24'h0, rows[i][15:8]});
      if (!rows[i][20]) chk(q, {24'h0, rows[i][7:0]}, "register read");
    end
    rst_n <= 0;
    @(posedge clk);
    rst_n <= 1;
    rw(0, ADDR_SERIAL_TIMER_CONTROL, 0);
    chk(q, 0, "control after reset");
    chk({sclo, sdao}, 0, "open drain levels");
    for (int i = 0; i < 2; i++)
    begin
      rw(1, ADDR_CH0_MODE, i ? 0 : 4);
      hit <= 2'b01;
      @(posedge clk);
      hit <= 0;
      rw(0, ADDR_CH0_STATUS, 0);
      chk(q[BIT_SECOND_MATCH], i, "second address flag");
    end
    for (int i = 0; i < 3; i++)
    begin
      rw(1, ADDR_SERIAL_TIMER_CONTROL, 32'(i == 2) << BIT_CH0_RATE);
      rw(1, ADDR_CH0_MODE, (i << CKS_LSB) | 3);
      repeat (2)
      begin
        wait_oe(0);
        wait_oe(1);
      end
      for (c = 0; c < 300 && scl_oe[0] === 1'b1; c++)
        @(posedge clk);
      chk(c, HALF_BASE << (i + 4 * (i == 2)), "clock low time");
    end
    rw(1, ADDR_CH0_MODE, 3);
    lose(0);
    drv <= 2'b10;
    repeat (4) @(posedge clk);
    chk(sda_oe[0], 0, "data still released");
    bend <= 2'b01;
    @(posedge clk);
    bend <= 0;
    repeat (2) @(posedge clk);
    chk(sda_oe[0], 1, "data driven again");
    drv <= 2'b11;
    rw(1, ADDR_CH0_STATUS, 0);
    chk(flag[0], 1, "write without read");
    rw(0, ADDR_CH0_STATUS, 0);
    chk(q[BIT_LOST], 1, "flag read as set");
    rw(1, ADDR_CH0_STATUS, 0);
    chk(flag[0], 0, "write after read");
    for (int m = 0; m < 2; m++)
    begin
      rw(1, ADDR_CH0_MODE, 3);
      lose(m[0]);
      rw(1, ADDR_CH0_MODE, m ? 1 : 3);
      acc(m[0], !m[0]);
      chk(flag[0], 1, "other direction access");
      acc(!m[0], m[0]);
      chk(flag[0], 0, "data access clears");
    end
    stop_test();
  end
endmodule : tb_top
`default_nettype wire
